// file: host_bus_if.sv
// Pin-level carrier joining the host end and the device end of the parallel port.
`timescale 1ns/1ns
`default_nettype none
`include "hpb_map.svh"

interface host_bus_if #(
  parameter int ADDR_W = `HPB_ADDR_W
);
  logic              cs_n;                 // Chip select, active low.
  logic              ctl_a_n;              // Read strobe or access_pulse_n.
  logic              ctl_b;                // Write strobe (low) or read/write direction.
  logic              byte_lane;            // Byte lane of a narrow transfer.
  logic              reg_select;           // High for register space, low for RAM.
  logic [ADDR_W-1:0] addr;                 // Word address.
  logic [15:0]       host_d;               // Data driven by the host.
  logic              host_d_oe;            // Host drives the data lines.
  logic [15:0]       dev_d;                // Data driven by the device.
  logic              dev_d_oe;             // Device drives the data lines.
  logic              wait_pin;             // Wait output, polarity set by strap.
  logic              bus_style_select;     // Strap: 1 separate strobes, 0 strobe plus direction.
  logic              bus_width_select;     // Strap: 1 sixteen bits, 0 eight bits.
  logic              endian_select;        // Strap: byte order.
  logic              wait_polarity_select; // Strap: 1 wait active high.
  wire  [15:0]       data;                 // Resolved data lines.

  // Resolves the shared data lines from the two enables; undriven lines read as zero.
  assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'h0000);

  modport device (
    input  cs_n, ctl_a_n, ctl_b, byte_lane, reg_select, addr, data,
    input  bus_style_select, bus_width_select, endian_select, wait_polarity_select,
    output dev_d, dev_d_oe, wait_pin
  );

  modport host (
    output cs_n, ctl_a_n, ctl_b, byte_lane, reg_select, addr, host_d, host_d_oe,
    input  data, wait_pin,
    input  bus_style_select, bus_width_select, endian_select, wait_polarity_select
  );
endinterface

`default_nettype wire

// file: hpb_bus_chk.sv
// Concurrent checks on the pins joining the host end and the device end.
`timescale 1ns/1ns
`default_nettype none

module hpb_bus_chk #(
  parameter int ADDR_W = 15
) (
  input wire logic              clk,                  // Clock.
  input wire logic              resetn,               // Reset, active low.
  input wire logic              cs_n,                 // Chip select.
  input wire logic              ctl_a_n,              // First control.
  input wire logic              ctl_b,                // Second control.
  input wire logic              byte_lane,            // Narrow lane.
  input wire logic              reg_select,           // Register space.
  input wire logic [ADDR_W-1:0] addr,                 // Word address.
  input wire logic              dev_d_oe,             // Device drives data.
  input wire logic              wait_pin,             // Wait output.
  input wire logic              bus_style_select,     // Style strap.
  input wire logic              bus_width_select,     // Width strap.
  input wire logic              wait_polarity_select  // Wait polarity strap.
);
  logic              rd_cs;
  logic              wr_cs;
  logic              wact;
  logic              st;
  logic              hit;
  logic              prev_rd;
  logic              prev_wr;
  logic              valid;
  logic [ADDR_W-1:0] last;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Decodes a selected read or write in either style and the active wait level.
  assign rd_cs = !cs_n && !ctl_a_n && (bus_style_select || ctl_b);
  assign wr_cs = !cs_n && (bus_style_select ? !ctl_b : (!ctl_a_n && !ctl_b));
  assign wact  = wait_pin == wait_polarity_select;
  assign st    = rd_cs && !prev_rd;
  assign hit   = valid && !reg_select
                 && addr == last + ADDR_W'(bus_width_select || !byte_lane);

  // Remembers the last RAM read so a following in-order read is known to be a hit.
  always_ff @(posedge clk) begin
    prev_rd <= rd_cs;
    prev_wr <= wr_cs;
    if (!resetn || (wr_cs && !prev_wr) || (st && reg_select)) begin
      valid <= 1'b0;
    end else if (st) begin
      valid <= 1'b1;
      last  <= addr;
    end
  end

  a_idle_no_wait: assert property (cs_n |-> !wact)
    else $error("wait active while not selected");
  a_write_no_wait: assert property (wr_cs |-> !wact)
    else $error("wait active during a write");
  a_wait_in_read: assert property (wact |-> rd_cs)
    else $error("wait active outside a read");
  a_wait_drop_data: assert property ($fell(wact) |-> dev_d_oe)
    else $error("wait dropped without read data");
  a_oe_after_read: assert property (dev_d_oe |-> $past(rd_cs))
    else $error("data driven without a read strobe");
  a_hit_no_wait: assert property (st && hit |-> !wact [*4])
    else $error("wait on an in-order RAM read");
  a_miss_waits: assert property (st && !hit && !reg_select |-> ##[1:12] wact)
    else $error("no wait on a new RAM read sequence");
  a_reg_waits: assert property (st && reg_select |-> ##[1:12] wact)
    else $error("no wait on a register read");

  c_hit: cover property (st && hit);
  c_reg: cover property (st && reg_select);
  c_narrow_write: cover property (wr_cs && !bus_width_select);
endmodule

`default_nettype wire

// file: hpb_device.sv
// Device end of the parallel host port: strobe decode, wait output and one-word read prefetch.
//
// Notes on behaviour
// - Accesses only while chip select is low.
// - Registers and RAM share timing; prefetch aside.
// - Style pin sets meaning of two controls.
// - Style low: strobe plus direction; high: two.
// - Width low: two bytes on low lines.
// - Width high: whole words on sixteen lines.
// - Narrow byte chosen by endian and lane.
// - Wide mode ignores lane; endian sets order.
// - Wait asserted on slow reads; host extends.
// - Polarity pin sets wait active level.
// - Each RAM read prefetches the next word.
// - First transfer of RAM sequence always waits.
// - Sequential RAM reads served without wait.
// - Register reads never prefetch, always wait.
// - Slow host may ignore wait entirely.
// - Host should time for fast prefetched reads.
// - Wait stays inactive during every write.
`timescale 1ns/1ns
`default_nettype none
`include "hpb_map.svh"

module hpb_device #(
  parameter int ADDR_W = `HPB_ADDR_W
) (
  input  wire logic              clk,       // System clock.
  input  wire logic              resetn,    // Synchronous reset, active low.
  input  wire logic              ce,        // Clock enable; state holds while low.
  host_bus_if.device             bus,       // Host bus pins.
  output logic                   mem_req,   // Storage request, held until acknowledged.
  output logic                   mem_we,    // Request is a write.
  output logic                   mem_reg,   // Request targets register space.
  output logic [ADDR_W-1:0]      mem_addr,  // Word address of the request.
  output logic [15:0]            mem_wdata, // Word to write.
  input  wire logic              mem_ack,   // One-cycle completion pulse.
  input  wire logic [15:0]       mem_rdata  // Read word, valid with mem_ack.
);

  // Whole state of the device end.
  typedef struct packed {
    hpb_pkg::dev_state_t st;
    logic                wait_pin;
    logic [15:0]         dout;
    logic                dout_oe;
    logic                cur_valid;
    logic [ADDR_W-1:0]   cur_addr;
    logic [15:0]         cur_word;
    logic                pf_valid;
    logic                pf_busy;
    logic [ADDR_W-1:0]   pf_addr;
    logic [15:0]         pf_word;
    logic [15:0]         wbuf;
    logic                rd_lane;
    logic                mem_req;
    logic                mem_we;
    logic                mem_reg;
    logic [ADDR_W-1:0]   mem_addr;
    logic [15:0]         mem_wdata;
  } dev_q_t;

  dev_q_t q;
  dev_q_t next_q;

  logic        access;
  logic        is_read;
  logic        wide;
  logic        lane;
  logic        wait_act;
  logic        hit_cur;
  logic        hit_pf;
  logic        pf_ready;
  logic        port_free;
  logic [15:0] pf_data;
  logic [15:0] wword;

  // Decodes the control pins according to the strapped bus style.
  always_comb begin
    if (bus.bus_style_select) begin
      access  = !bus.cs_n && (!bus.ctl_a_n || !bus.ctl_b);
      is_read = !bus.ctl_a_n;
    end else begin
      access  = !bus.cs_n && !bus.ctl_a_n;
      is_read = bus.ctl_b;
    end
    wide = bus.bus_width_select;
    lane = wide ? 1'b0 : bus.byte_lane;
  end

  // Decides whether a RAM read is sequential and can be served without waiting.
  always_comb begin
    hit_cur = !wide && lane && !bus.reg_select && q.cur_valid
              && (bus.addr == q.cur_addr);
    // A prefetch landing in this very cycle counts as ready, so a fast host is not cut short.
    pf_ready  = q.pf_valid || (q.pf_busy && q.mem_req && mem_ack);
    pf_data   = q.pf_valid ? q.pf_word : mem_rdata;
    port_free = !q.mem_req || mem_ack;
    hit_pf  = !lane && !bus.reg_select && pf_ready
              && (bus.addr == q.pf_addr);
    wword   = hpb_pkg::take_word(q.wbuf, bus.data, wide, bus.endian_select, lane);
  end

  // Next-state logic for the sequencer, prefetch buffer and storage port.
  always_comb begin
    next_q   = q;
    wait_act = 1'b0;
    // A completing request frees the port; a finished prefetch fills the buffer.
    if (mem_ack && q.mem_req) begin
      next_q.mem_req = 1'b0;
      if (q.pf_busy) begin
        next_q.pf_busy  = 1'b0;
        next_q.pf_valid = 1'b1;
        next_q.pf_word  = mem_rdata;
      end
    end
    case (q.st)
      hpb_pkg::D_IDLE: begin
        next_q.dout_oe = 1'b0;
        // A new access waits for a free storage port; a second-lane hit needs no port.
        if (access && (port_free || (is_read && hit_cur))) begin
          if (is_read) begin
            if (hit_cur) begin
              next_q.dout    = hpb_pkg::bus_word(q.cur_word, wide, bus.endian_select, lane);
              next_q.dout_oe = 1'b1;
              next_q.st      = hpb_pkg::D_SERVE;
            end else if (hit_pf) begin
              next_q.cur_word  = pf_data;
              next_q.cur_addr  = q.pf_addr;
              next_q.cur_valid = 1'b1;
              next_q.pf_valid  = 1'b0;
              next_q.dout      = hpb_pkg::bus_word(pf_data, wide, bus.endian_select, lane);
              next_q.dout_oe   = 1'b1;
              next_q.mem_req   = 1'b1;
              next_q.mem_we    = 1'b0;
              next_q.mem_reg   = 1'b0;
              next_q.mem_addr  = ADDR_W'(q.pf_addr + 1'b1);
              next_q.pf_busy   = 1'b1;
              next_q.pf_addr   = ADDR_W'(q.pf_addr + 1'b1);
              next_q.st        = hpb_pkg::D_SERVE;
            end else begin
              // Start of a new sequence or a register read: old prefetch is stale.
              next_q.pf_valid  = 1'b0;
              next_q.cur_valid = 1'b0;
              wait_act         = 1'b1;
              next_q.mem_req   = 1'b1;
              next_q.mem_we    = 1'b0;
              next_q.mem_reg   = bus.reg_select;
              next_q.mem_addr  = bus.addr;
              next_q.rd_lane   = lane;
              next_q.st        = hpb_pkg::D_FETCH;
            end
          end else if (!wide && !lane) begin
            // First byte of a narrow write is held until its partner arrives.
            next_q.wbuf = wword;
            next_q.st   = hpb_pkg::D_HOLD;
          end else begin
            // A write may change any held word, so both holding registers are dropped.
            next_q.pf_valid  = 1'b0;
            next_q.cur_valid = 1'b0;
            next_q.mem_req   = 1'b1;
            next_q.mem_we    = 1'b1;
            next_q.mem_reg   = bus.reg_select;
            next_q.mem_addr  = bus.addr;
            next_q.mem_wdata = wword;
            next_q.st        = hpb_pkg::D_HOLD;
          end
        end
      end
      hpb_pkg::D_FETCH: begin
        wait_act = 1'b1;
        // The demanded word arrives: present it, drop wait, then for a RAM read look one word ahead.
        if (mem_ack) begin
          wait_act       = 1'b0;
          next_q.dout    = hpb_pkg::bus_word(mem_rdata, wide, bus.endian_select, q.rd_lane);
          next_q.dout_oe = 1'b1;
          next_q.st      = hpb_pkg::D_SERVE;
          if (!q.mem_reg) begin
            next_q.cur_word  = mem_rdata;
            next_q.cur_addr  = q.mem_addr;
            next_q.cur_valid = 1'b1;
            next_q.mem_req   = 1'b1;
            next_q.mem_addr  = ADDR_W'(q.mem_addr + 1'b1);
            next_q.pf_busy   = 1'b1;
            next_q.pf_addr   = ADDR_W'(q.mem_addr + 1'b1);
          end
        end
      end
      hpb_pkg::D_SERVE: begin
        // Data stay on the lines until the host ends the read.
        if (!access) begin
          next_q.dout_oe = 1'b0;
          next_q.st      = hpb_pkg::D_IDLE;
        end
      end
      hpb_pkg::D_HOLD: begin
        if (!access) begin
          next_q.st = hpb_pkg::D_IDLE;
        end
      end
      default: begin
        next_q.st      = hpb_pkg::D_IDLE;
        next_q.dout_oe = 1'b0;
      end
    endcase
    // The pin follows the strapped polarity.
    next_q.wait_pin = wait_act ^ !bus.wait_polarity_select;
  end

  // Registers the whole state; clock enable freezes it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q           <= '0;
      q.st        <= hpb_pkg::D_IDLE;
      q.wait_pin  <= !bus.wait_polarity_select;
      q.dout      <= `HPB_WORD_RST;
      q.cur_word  <= `HPB_WORD_RST;
      q.pf_word   <= `HPB_WORD_RST;
      q.wbuf      <= `HPB_WORD_RST;
      q.mem_wdata <= `HPB_WORD_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register.
  assign bus.dev_d    = q.dout;
  assign bus.dev_d_oe = q.dout_oe;
  assign bus.wait_pin = q.wait_pin;
  assign mem_req      = q.mem_req;
  assign mem_we       = q.mem_we;
  assign mem_reg      = q.mem_reg;
  assign mem_addr     = q.mem_addr;
  assign mem_wdata    = q.mem_wdata;

endmodule

`default_nettype wire

// file: hpb_host.sv
// Host end of the parallel port: turns word commands into one or two strobed bus cycles.
`timescale 1ns/1ns
`default_nettype none
`include "hpb_map.svh"

module hpb_host #(
  parameter int ADDR_W = `HPB_ADDR_W
) (
  input  wire logic              clk,       // System clock.
  input  wire logic              resetn,    // Synchronous reset, active low.
  input  wire logic              ce,        // Clock enable; state holds while low.
  host_bus_if.host               bus,       // Host bus pins.
  input  wire logic              cmd_valid, // Command offered.
  output logic                   cmd_ready, // Host end can take a command.
  input  wire logic              cmd_write, // Command is a write.
  input  wire logic              cmd_reg,   // Command targets register space.
  input  wire logic [ADDR_W-1:0] cmd_addr,  // Word address.
  input  wire logic [15:0]       cmd_wdata, // Word to write.
  output logic                   rsp_valid, // One-cycle pulse: read word ready.
  output logic [15:0]            rsp_rdata  // Read word.
);

  // Whole state of the host end.
  typedef struct packed {
    hpb_pkg::host_state_t st;
    logic                 cs_n;
    logic                 ctl_a_n;
    logic                 ctl_b;
    logic                 lane;
    logic                 reg_sel;
    logic [ADDR_W-1:0]    addr;
    logic [15:0]          dout;
    logic                 dout_oe;
    logic [7:0]           cnt;
    logic                 write;
    logic [15:0]          wdata;
    logic [15:0]          rword;
    logic                 cmd_ready;
    logic                 rsp_valid;
  } host_q_t;

  host_q_t q;
  host_q_t next_q;

  logic wide;
  logic wait_seen;

  // Control pin levels while a strobe is active, by style and direction.
  function automatic logic [1:0] ctl_on(input logic style, input logic write);
    if (style) begin
      ctl_on = write ? 2'h2 : 2'h1;
    end else begin
      ctl_on = {1'b0, !write};
    end
  endfunction

  // Strap decode and wait recognition at the strapped polarity.
  // This host honours wait on reads and ignores it on writes; only a host slow on every read may leave it unwatched.
  always_comb begin
    wide      = bus.bus_width_select;
    wait_seen = bus.wait_polarity_select ? bus.wait_pin : !bus.wait_pin;
  end

  // Next-state logic for the bus cycle sequencer.
  always_comb begin
    next_q           = q;
    next_q.rsp_valid = 1'b0;
    case (q.st)
      hpb_pkg::H_IDLE: begin
        if (cmd_valid && q.cmd_ready) begin
          next_q.cmd_ready         = 1'b0;
          next_q.write             = cmd_write;
          next_q.wdata             = cmd_wdata;
          next_q.addr              = cmd_addr;
          next_q.reg_sel           = cmd_reg;
          next_q.lane              = 1'b0;
          next_q.cs_n              = 1'b0;
          {next_q.ctl_a_n, next_q.ctl_b} = ctl_on(bus.bus_style_select, cmd_write);
          next_q.dout              = hpb_pkg::bus_word(cmd_wdata, wide, bus.endian_select, 1'b0);
          next_q.dout_oe           = cmd_write;
          next_q.cnt               = 8'(`HPB_STROBE_CYC - 1);
          next_q.st                = hpb_pkg::H_STROBE;
        end
      end
      hpb_pkg::H_STROBE: begin
        // Strobe is held its least time, then longer while the device asks to wait.
        if (q.cnt != 8'h00) begin
          next_q.cnt = q.cnt - 8'h01;
        end else if (q.write || !wait_seen) begin
          if (!q.write) begin
            next_q.rword = hpb_pkg::take_word(q.rword, bus.data, wide,
                                              bus.endian_select, q.lane);
          end
          next_q.cs_n    = 1'b1;
          next_q.ctl_a_n = 1'b1;
          next_q.ctl_b   = bus.bus_style_select ? 1'b1 : q.ctl_b;
          next_q.dout_oe = 1'b0;
          next_q.cnt     = 8'(`HPB_INACT_CYC - 1);
          next_q.st      = hpb_pkg::H_RECOV;
        end
      end
      hpb_pkg::H_RECOV: begin
        if (q.cnt != 8'h00) begin
          next_q.cnt = q.cnt - 8'h01;
        end else if (!wide && !q.lane) begin
          // Second byte of a narrow word on the low lines.
          next_q.lane    = 1'b1;
          next_q.cs_n    = 1'b0;
          {next_q.ctl_a_n, next_q.ctl_b} = ctl_on(bus.bus_style_select, q.write);
          next_q.dout    = hpb_pkg::bus_word(q.wdata, wide, bus.endian_select, 1'b1);
          next_q.dout_oe = q.write;
          next_q.cnt     = 8'(`HPB_STROBE_CYC - 1);
          next_q.st      = hpb_pkg::H_STROBE;
        end else begin
          next_q.rsp_valid = !q.write;
          next_q.cmd_ready = 1'b1;
          next_q.st        = hpb_pkg::H_IDLE;
        end
      end
      default: begin
        next_q.st = hpb_pkg::H_IDLE;
      end
    endcase
  end

  // Registers the whole state; clock enable freezes it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q           <= '0;
      q.st        <= hpb_pkg::H_IDLE;
      q.cs_n      <= 1'b1;
      q.ctl_a_n   <= 1'b1;
      q.ctl_b     <= 1'b1;
      q.dout      <= `HPB_WORD_RST;
      q.rword     <= `HPB_WORD_RST;
      q.cmd_ready <= 1'b1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register.
  assign bus.cs_n       = q.cs_n;
  assign bus.ctl_a_n    = q.ctl_a_n;
  assign bus.ctl_b      = q.ctl_b;
  assign bus.byte_lane  = q.lane;
  assign bus.reg_select = q.reg_sel;
  assign bus.addr       = q.addr;
  assign bus.host_d     = q.dout;
  assign bus.host_d_oe  = q.dout_oe;
  assign cmd_ready      = q.cmd_ready;
  assign rsp_valid      = q.rsp_valid;
  assign rsp_rdata      = q.rword;

endmodule

`default_nettype wire

// file: hpb_map.svh
// Constants for the parallel host bus port: widths, reset values and timing counts.
`ifndef HPB_MAP_SVH
`define HPB_MAP_SVH

// Bus and address widths.
`define HPB_DATA_W        16
`define HPB_ADDR_W        15

// Reset value of held words and data outputs.
`define HPB_WORD_RST      16'h0000

// Clock period and host-side strobe timing, in nanoseconds.
`define HPB_CLK_PERIOD_NS 4
`define HPB_STROBE_MIN_NS 12
`define HPB_INACT_MIN_NS  8

// Least strobe and recovery times rounded up to whole clock cycles.
`define HPB_STROBE_CYC ((`HPB_STROBE_MIN_NS + `HPB_CLK_PERIOD_NS - 1) / `HPB_CLK_PERIOD_NS)
`define HPB_INACT_CYC  ((`HPB_INACT_MIN_NS + `HPB_CLK_PERIOD_NS - 1) / `HPB_CLK_PERIOD_NS)

`endif

// file: hpb_pkg.sv
// Types and byte-lane helpers shared by both ends of the parallel host bus port.
package hpb_pkg;

  // Device-end sequencer states.
  typedef enum logic [1:0] {
    D_IDLE  = 2'h0,
    D_FETCH = 2'h1,
    D_SERVE = 2'h2,
    D_HOLD  = 2'h3
  } dev_state_t;

  // Host-end sequencer states.
  typedef enum logic [1:0] {
    H_IDLE   = 2'h0,
    H_STROBE = 2'h1,
    H_RECOV  = 2'h2
  } host_state_t;

  // Places a word on the bus: swapped or straight in wide mode, one byte on the low lines else.
  function automatic logic [15:0] bus_word(input logic [15:0] word, input logic wide,
                                           input logic endian, input logic lane);
    logic hi;
    hi = lane ^ endian;
    if (wide) begin
      bus_word = endian ? {word[7:0], word[15:8]} : word;
    end else begin
      bus_word = {8'h00, (hi ? word[15:8] : word[7:0])};
    end
  endfunction

  // Takes a word off the bus, merging a single byte into the held word in narrow mode.
  function automatic logic [15:0] take_word(input logic [15:0] old, input logic [15:0] bus,
                                            input logic wide, input logic endian,
                                            input logic lane);
    logic hi;
    hi = lane ^ endian;
    if (wide) begin
      take_word = endian ? {bus[7:0], bus[15:8]} : bus;
    end else if (hi) begin
      take_word = {bus[7:0], old[7:0]};
    end else begin
      take_word = {old[15:8], bus[7:0]};
    end
  endfunction

endpackage

// file: testbench.sv
// Self-checking bench joining both ends of the parallel host port.
`timescale 1ns/1ns
`default_nettype none
`include "hpb_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

module testbench;
  logic        clk, resetn, cmd_valid, cmd_ready, cmd_write, cmd_reg, rsp_valid;
  logic        mem_req, mem_we, mem_reg, mem_ack, reg_seen, ce;
  logic [14:0] cmd_addr, mem_addr;
  logic [15:0] cmd_wdata, rsp_rdata, mem_wdata, mem_rdata, rd, seen;
  logic [15:0] mem [0:31];
  int          mismatches = 0, tests_run = 0, waits, cnt, lat, i;

  host_bus_if #(.ADDR_W(15)) host_bus_if_inst ();
  hpb_host #(.ADDR_W(15)) hpb_host_inst (.clk(clk), .resetn(resetn), .ce(ce),
    .bus(host_bus_if_inst.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hpb_device #(.ADDR_W(15)) hpb_device_inst (.clk(clk), .resetn(resetn), .ce(ce),
    .bus(host_bus_if_inst.device), .mem_req(mem_req), .mem_we(mem_we), .mem_reg(mem_reg),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  hpb_bus_chk #(.ADDR_W(15)) hpb_bus_chk_inst (.clk(clk), .resetn(resetn),
    .cs_n(host_bus_if_inst.cs_n), .ctl_a_n(host_bus_if_inst.ctl_a_n),
    .ctl_b(host_bus_if_inst.ctl_b), .byte_lane(host_bus_if_inst.byte_lane),
    .reg_select(host_bus_if_inst.reg_select), .addr(host_bus_if_inst.addr),
    .dev_d_oe(host_bus_if_inst.dev_d_oe), .wait_pin(host_bus_if_inst.wait_pin),
    .bus_style_select(host_bus_if_inst.bus_style_select),
    .bus_width_select(host_bus_if_inst.bus_width_select),
    .wait_polarity_select(host_bus_if_inst.wait_polarity_select));

  // Clock of 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Storage behind the device; lat idle cycles make it prompt or slow; reg_seen keeps the space.
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (mem_req) reg_seen <= mem_reg;
    if (mem_req && !mem_ack) begin
      cnt <= cnt + 1;
      if (cnt >= lat) begin
        cnt       <= 0;
        mem_ack   <= 1'b1;
        mem_rdata <= mem[mem_addr[4:0]];
        if (mem_we) mem[mem_addr[4:0]] <= mem_wdata;
      end
    end
  end

  // Counts settled wait cycles and keeps the last word the device put on the lines.
  always @(negedge clk) begin
    if (host_bus_if_inst.wait_pin === host_bus_if_inst.wait_polarity_select) waits++;
    if (host_bus_if_inst.dev_d_oe) seen = host_bus_if_inst.data;
  end

  // Word stored at an address.
  function automatic logic [15:0] wv(input logic [14:0] a);
    return {a[7:0] ^ 8'h5A, ~a[7:0]};
  endfunction

  // Value expected on the data lines for the last transfer of a word.
  function automatic logic [15:0] on_wire(input logic [15:0] x, input logic wd, e);
    if (wd) return e ? {x[7:0], x[15:8]} : x;
    return {8'h00, e ? x[7:0] : x[15:8]};
  endfunction

  // Issues one command and waits for the host end to finish it.
  task automatic op(input logic w, r, input logic [14:0] a);
    int n;
    waits = 0;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_reg   <= r;
    cmd_addr  <= a;
    cmd_wdata <= wv(a);
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (rsp_valid) rd = rsp_rdata;
      if (cmd_ready && (w || rsp_valid)) break;
    end
    `CHK(n < 400, 1'b1)
    @(posedge clk);
  endtask

  // One strap setting: writes, in-order reads, a jump back and register reads.
  task automatic t_mode(input logic [3:0] m);
    logic [14:0] b;
    int          k;
    b = {11'h000, m} + 15'h0001;
    host_bus_if_inst.bus_style_select     <= m[0];
    host_bus_if_inst.bus_width_select     <= m[1];
    host_bus_if_inst.endian_select        <= m[2];
    host_bus_if_inst.wait_polarity_select <= m[3];
    lat = m[0] ? 1 : 5;
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Clock enable low freezes both ends, so an offered command must not be taken.
    ce        <= 1'b0;
    cmd_valid <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK({cmd_ready, host_bus_if_inst.cs_n}, 2'h3)
    @(posedge clk);
    ce        <= 1'b1;
    cmd_valid <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 3; k++) begin
      op(1'b1, 1'b0, b + 15'(k));
      `CHK(waits, 0)
    end
    for (k = 0; k < 3; k++) begin
      op(1'b0, 1'b0, b + 15'(k));
      `CHK(rd, wv(b + 15'(k)))
      `CHK(m[1] ? seen : {8'h00, seen[7:0]}, on_wire(wv(b + 15'(k)), m[1], m[2]))
      `CHK(waits == 0, k > 0)
    end
    op(1'b0, 1'b0, b);
    `CHK(waits > 0, 1'b1)
    `CHK(reg_seen, 1'b0)
    for (k = 1; k < 3; k++) begin
      op(1'b0, 1'b1, b + 15'(k));
      `CHK(rd, wv(b + 15'(k)))
      `CHK(waits > 0, 1'b1)
      `CHK(reg_seen, 1'b1)
    end
    $display("Mode %h done, %0d mismatches so far", m, mismatches);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence over every strap combination.
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_reg = 1'b0;
    cmd_addr = 15'h0000;
    cmd_wdata = 16'h0000;
    host_bus_if_inst.bus_style_select = 1'b1;
    host_bus_if_inst.bus_width_select = 1'b1;
    host_bus_if_inst.endian_select = 1'b0;
    host_bus_if_inst.wait_polarity_select = 1'b1;
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    cnt = 0;
    lat = 1;
    ce = 1'b1;
    @(posedge clk);
    for (i = 0; i < 16; i++) t_mode(4'(i));
    wrap_up;
  end

  // Cuts a hang short.
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule

`default_nettype wire
